/* rtl/uicf_ctrl.sv */
// Per-channel interrupt prioritiser and FIFO control with Wishbone slave
// Summary of operation
// R1: Receive data interrupt on character or trigger
// R2: Transmit ready on empty/below trigger, enable
// R3: Overrun immediate; other errors on read-out, or at once in immediate error mode
// R4: Mask bits 7:4 need enhanced functions
// R5: Interrupt on RTS and CTS rising
// R6: RTS/CTS interrupts only under auto flow
// R7: Source shows top pending only, held
// R8: Seven priority codes in source bits 5:0
// R9: Bit 0 low when pending, reset high
// R10: Bits 5:4 enhanced; Xoff held until Xon or source read
// R11: Bits 7:6 mirror FIFO enable
// R12: Timeout is four chars plus twelve bits
// R13: Transmit ready from empty transmitter under RS-485
// R14: Modem bits 0-3, line bits 1-4 interrupt
// R15: Status reads clear line, modem, flow interrupts
// R16: Data below trigger; timeout clears on read
// R17: Transmit ready clears on source read, write
// R18: Xoff/special clear on source read or rx
// R19: Other setup bits need enable bit set
// R20: Setup bit 1 resets receive FIFO, self-clears
// R21: Setup bit 2 resets transmit FIFO, self-clears
// R22: Transmit trigger from setup 5:4 and table
// R23: Setup 7:6 with table picks receive trigger
// R24: Line bit 1 overrun, 2-4 head errors
// R25: Timeout restarts on character or read
// R26: Interrupt output when pending and enabled
`include "uicf_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module uicf_ctrl #(
  parameter int FIFO_DEPTH = 64,
  parameter int LVL_W = 7
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  output logic err_o,
  // Receiver, transmitter and modem side events
  input wire logic rx_char_push_i,
  input wire logic rx_char_pop_i,
  input wire logic rx_overrun_i,
  input wire logic [2:0] rx_head_err_i,
  input wire logic rx_xoff_match_i,
  input wire logic rx_xon_match_i,
  input wire logic rx_special_match_i,
  input wire logic [3:0] modem_delta_i,
  input wire logic [3:0] modem_level_i,
  input wire logic [LVL_W-1:0] rx_level_i,
  input wire logic [LVL_W-1:0] tx_level_i,
  input wire logic tx_push_i,
  input wire logic tx_all_empty_i,
  input wire logic rts_out_i,
  input wire logic cts_pin_i,
  // Character time base from the word format and baud rate
  input wire logic [3:0] char_bits_i,
  input wire logic bit_tick_i,
  // Control outputs to the FIFOs and pins
  output logic fifo_en_o,
  output logic rx_fifo_clr_o,
  output logic tx_fifo_clr_o,
  output logic dma_mode_o,
  output logic sleep_en_o,
  output logic irq_o
);

  logic [7:0] interrupt_mask;
  logic [7:0] fifo_setup;
  logic [7:0] ext_ctrl;
  logic [7:0] line_status;
  logic [3:0] modem_status;
  logic rx_clr;
  logic tx_clr;
  logic cts_s1, cts_s2, cts_prev;
  logic rts_prev;
  logic tx_empty_prev;
  logic line_pend, tmo_pend, tx_pend, xoff_pend, flow_pend, mdm_pend;
  logic tx_reload_over;
  logic xoff_flag, spec_flag;
  logic [15:0] tmo_cnt;
  logic tmo_run;
  uicf_pkg::uicf_sel_t cur_sel, next_sel;
  logic [5:0] src_code;
  logic [LVL_W-1:0] rx_trig, tx_trig;
  logic enh, fifo_en;
  logic bus_req, wr, rd, hit;
  logic rd_source, rd_line, rd_modem, wr_thr_evt;
  logic rx_data_pend, tx_cond, tx_rise;
  logic [7:0] mask_eff;
  logic [7:0] source_byte;

  assign enh = ext_ctrl[`UICF_EXT_ENH];
  assign fifo_en = fifo_setup[`UICF_SETUP_EN];
  assign bus_req = cyc_i & stb_i & ~ack_o & ~err_o;
  assign wr = bus_req & we_i & hit & sel_i[0];
  assign rd = bus_req & ~we_i & hit;
  assign rd_source = rd & (adr_i == `UICF_OFS_SOURCE);
  assign rd_line = rd & (adr_i == `UICF_OFS_LINE_STATUS);
  assign rd_modem = rd & (adr_i == `UICF_OFS_MODEM_STATUS);
  assign wr_thr_evt = tx_push_i;

  // Mask bits 7:4 count only with enhanced functions on
  assign mask_eff = enh ? interrupt_mask
                        : {4'h0, interrupt_mask[3:0]}; // see R4
  assign sleep_en_o = mask_eff[4]; // see R4

  function automatic logic [LVL_W-1:0] lvl(input int v);
    lvl = LVL_W'(v);
  endfunction

  // Trigger tables; table choices 1 and 2 serve both directions, choice 0 receive only
  always_comb begin
    case ({ext_ctrl[`UICF_EXT_TBL_HI], ext_ctrl[`UICF_EXT_TBL_LO],
           fifo_setup[7:6]}) // see R23
      4'h0: rx_trig = lvl(1);
      4'h1: rx_trig = lvl(4);
      4'h2: rx_trig = lvl(8);
      4'h3: rx_trig = lvl(14);
      4'h4: rx_trig = lvl(8);
      4'h5: rx_trig = lvl(16);
      4'h6: rx_trig = lvl(24);
      4'h7: rx_trig = lvl(28);
      4'h8: rx_trig = lvl(8);
      4'h9: rx_trig = lvl(16);
      4'hA: rx_trig = lvl(56);
      4'hB: rx_trig = lvl(60);
      default: rx_trig = lvl(1);
    endcase
    case ({ext_ctrl[`UICF_EXT_TBL_HI], ext_ctrl[`UICF_EXT_TBL_LO],
           fifo_setup[5:4]}) // see R22
      4'h4: tx_trig = lvl(16);
      4'h5: tx_trig = lvl(8);
      4'h6: tx_trig = lvl(24);
      4'h7: tx_trig = lvl(30);
      4'h8: tx_trig = lvl(8);
      4'h9: tx_trig = lvl(16);
      4'hA: tx_trig = lvl(32);
      4'hB: tx_trig = lvl(56);
      default: tx_trig = lvl(1);
    endcase
  end

  always_comb begin
    hit = 1'b1;
    case (adr_i)
      `UICF_OFS_MASK, `UICF_OFS_SOURCE, `UICF_OFS_SETUP,
      `UICF_OFS_EXT_CTRL, `UICF_OFS_LINE_STATUS,
      `UICF_OFS_MODEM_STATUS, `UICF_OFS_RX_LEVEL,
      `UICF_OFS_TX_LEVEL, `UICF_OFS_TIMEOUT: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Bus handshake: one wait state, unmapped addresses get err
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o & ~err_o & hit;
      err_o <= cyc_i & stb_i & ~ack_o & ~err_o & ~hit;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      interrupt_mask <= `UICF_RESET_BYTE;
      ext_ctrl <= `UICF_RESET_BYTE;
    end else if (wr) begin
      if (adr_i == `UICF_OFS_MASK)
        interrupt_mask <= dat_i[7:0];
      if (adr_i == `UICF_OFS_EXT_CTRL)
        ext_ctrl <= {1'b0, dat_i[6:0]};
    end
  end

  // Setup writes without the enable bit only clear it
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      fifo_setup <= `UICF_RESET_BYTE;
    end else if (wr && adr_i == `UICF_OFS_SETUP) begin
      if (dat_i[`UICF_SETUP_EN]) begin // see R19
        fifo_setup[0] <= 1'b1;
        fifo_setup[3] <= dat_i[`UICF_SETUP_DMA];
        fifo_setup[7:6] <= dat_i[7:6];
        if (enh)
          fifo_setup[5:4] <= dat_i[5:4]; // see R22
      end else begin
        fifo_setup[0] <= 1'b0;
      end
    end
  end

  // FIFO reset strobes last one cycle and are never stored
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rx_clr <= 1'b0;
      tx_clr <= 1'b0;
    end else begin
      rx_clr <= wr && adr_i == `UICF_OFS_SETUP
                && dat_i[`UICF_SETUP_EN] && fifo_en
                && dat_i[`UICF_SETUP_RXRST]; // see R20
      tx_clr <= wr && adr_i == `UICF_OFS_SETUP
                && dat_i[`UICF_SETUP_EN] && fifo_en
                && dat_i[`UICF_SETUP_TXRST]; // see R21
    end
  end
  assign rx_fifo_clr_o = rx_clr;
  assign tx_fifo_clr_o = tx_clr;
  assign fifo_en_o = fifo_en;
  assign dma_mode_o = fifo_setup[`UICF_SETUP_DMA];

  // Line status: overrun at once, head errors latched on pop, or at once in immediate error mode
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      line_status <= `UICF_RESET_BYTE;
    end else begin
      line_status[1] <= rx_overrun_i | (line_status[1] & ~rd_line); // see R24
      if (ext_ctrl[`UICF_EXT_IMM_ERR])
        line_status[4:2] <= rx_head_err_i
                          | (line_status[4:2] & {3{~rd_line}}); // see R3
      else if (rx_char_pop_i)
        line_status[4:2] <= rx_head_err_i; // see R3
      else if (rd_line)
        line_status[4:2] <= 3'h0;
    end
  end
  assign line_pend = |line_status[4:1]; // see R14

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      modem_status <= 4'h0;
    end else begin
      modem_status <= modem_delta_i
                    | (modem_status & {4{~rd_modem}}); // see R15
    end
  end
  assign mdm_pend = |modem_status; // see R14

  // CTS pin is asynchronous; RTS is our own output
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cts_s1 <= 1'b0;
      cts_s2 <= 1'b0;
      cts_prev <= 1'b0;
      rts_prev <= 1'b0;
    end else begin
      cts_s1 <= cts_pin_i;
      cts_s2 <= cts_s1;
      cts_prev <= cts_s2;
      rts_prev <= rts_out_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      flow_pend <= 1'b0;
    end else if ((cts_s2 & ~cts_prev & ext_ctrl[`UICF_EXT_AUTO_CTS]
                  & mask_eff[`UICF_MASK_CTS])
              || (rts_out_i & ~rts_prev & ext_ctrl[`UICF_EXT_AUTO_RTS]
                  & mask_eff[`UICF_MASK_RTS])) begin
      flow_pend <= 1'b1; // see R5, R6
    end else if (rd_modem) begin
      flow_pend <= 1'b0; // see R15
    end
  end

  // Xoff stays until Xon or source read; special char until source read or next char
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      xoff_flag <= 1'b0;
    end else if (rx_xoff_match_i && enh) begin
      xoff_flag <= 1'b1; // see R10
    end else if (rx_xon_match_i || rd_source) begin
      xoff_flag <= 1'b0; // see R18
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spec_flag <= 1'b0;
    end else if (rx_special_match_i && enh) begin
      spec_flag <= 1'b1; // see R10
    end else if (rx_char_push_i || rd_source) begin
      spec_flag <= 1'b0; // see R18
    end
  end
  assign xoff_pend = xoff_flag | spec_flag;

  assign rx_data_pend = fifo_en ? (rx_level_i >= rx_trig)
                                : (rx_level_i != lvl(0)); // see R1, R16

  // Whether the last reload pushed the level above trigger
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_reload_over <= 1'b0;
    end else if (tx_level_i > tx_trig) begin
      tx_reload_over <= 1'b1;
    end else if (tx_level_i == lvl(0)) begin
      tx_reload_over <= 1'b0;
    end
  end

  always_comb begin
    if (ext_ctrl[`UICF_EXT_RS485])
      tx_cond = tx_all_empty_i; // see R13
    else if (!fifo_en)
      tx_cond = (tx_level_i == lvl(0));
    else if (tx_reload_over)
      tx_cond = (tx_level_i < tx_trig); // see R22
    else
      tx_cond = (tx_level_i == lvl(0));
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_empty_prev <= 1'b0;
    end else begin
      tx_empty_prev <= tx_cond & mask_eff[`UICF_MASK_TXREADY];
    end
  end
  // Rising of condition, or enable set while already empty
  assign tx_rise = tx_cond & mask_eff[`UICF_MASK_TXREADY] & ~tx_empty_prev;

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tx_pend <= 1'b0;
    end else if (tx_rise) begin
      tx_pend <= 1'b1; // see R2
    end else if ((rd_source && cur_sel == uicf_pkg::UICF_SEL_TXREADY)
                 || wr_thr_evt || !tx_cond) begin
      tx_pend <= 1'b0; // see R17
    end
  end

  // Timeout counts bit ticks; restarts on char or read
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      tmo_cnt <= 16'h0000;
      tmo_run <= 1'b0;
      tmo_pend <= 1'b0;
    end else if (rx_char_push_i || rx_char_pop_i) begin
      tmo_cnt <= 16'h0000; // see R25
      tmo_run <= 1'b1;
      tmo_pend <= rx_char_pop_i ? 1'b0 : tmo_pend; // see R16
    end else if (rx_level_i == lvl(0)) begin
      tmo_run <= 1'b0;
    end else if (tmo_run && bit_tick_i) begin
      if (tmo_cnt + 16'h0001 >= 16'(`UICF_TMO_CHARS) * 16'(char_bits_i)
          + 16'(`UICF_TMO_BITS)) begin
        tmo_pend <= fifo_en; // see R12
        tmo_run <= 1'b0;
      end else begin
        tmo_cnt <= tmo_cnt + 16'h0001;
      end
    end
  end

  // Priority pick among enabled sources
  always_comb begin
    next_sel = uicf_pkg::UICF_SEL_NONE;
    if (line_pend && mask_eff[`UICF_MASK_LINE])
      next_sel = uicf_pkg::UICF_SEL_LINE;
    else if (tmo_pend && mask_eff[`UICF_MASK_RXDATA])
      next_sel = uicf_pkg::UICF_SEL_TIMEOUT;
    else if (rx_data_pend && mask_eff[`UICF_MASK_RXDATA])
      next_sel = uicf_pkg::UICF_SEL_RXDATA;
    else if (tx_pend)
      next_sel = uicf_pkg::UICF_SEL_TXREADY;
    else if (mdm_pend && mask_eff[`UICF_MASK_MODEM])
      next_sel = uicf_pkg::UICF_SEL_MODEM;
    else if (xoff_pend && mask_eff[`UICF_MASK_XOFF])
      next_sel = uicf_pkg::UICF_SEL_XOFF;
    else if (flow_pend)
      next_sel = uicf_pkg::UICF_SEL_FLOW;
  end

  // Presented source holds until serviced, or masked except transmit ready and flow; receive data yields to line status
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cur_sel <= uicf_pkg::UICF_SEL_NONE;
    end else begin
      case (cur_sel)
        uicf_pkg::UICF_SEL_LINE:
          if (!line_pend || !mask_eff[`UICF_MASK_LINE]) cur_sel <= next_sel;
        uicf_pkg::UICF_SEL_TIMEOUT:
          if (!tmo_pend || !mask_eff[`UICF_MASK_RXDATA]) cur_sel <= next_sel;
        uicf_pkg::UICF_SEL_RXDATA:
          if (!rx_data_pend || !mask_eff[`UICF_MASK_RXDATA]
              || next_sel == uicf_pkg::UICF_SEL_LINE) cur_sel <= next_sel;
        uicf_pkg::UICF_SEL_TXREADY:
          if (!tx_pend) cur_sel <= next_sel;
        uicf_pkg::UICF_SEL_MODEM:
          if (!mdm_pend || !mask_eff[`UICF_MASK_MODEM]) cur_sel <= next_sel;
        uicf_pkg::UICF_SEL_XOFF:
          if (!xoff_pend || !mask_eff[`UICF_MASK_XOFF]) cur_sel <= next_sel;
        uicf_pkg::UICF_SEL_FLOW:
          if (!flow_pend) cur_sel <= next_sel;
        default: cur_sel <= next_sel; // see R7
      endcase
    end
  end

  always_comb begin
    case (cur_sel) // see R8
      uicf_pkg::UICF_SEL_LINE: src_code = `UICF_SRC_LINE;
      uicf_pkg::UICF_SEL_TIMEOUT: src_code = `UICF_SRC_TIMEOUT;
      uicf_pkg::UICF_SEL_RXDATA: src_code = `UICF_SRC_RXDATA;
      uicf_pkg::UICF_SEL_TXREADY: src_code = `UICF_SRC_TXREADY;
      uicf_pkg::UICF_SEL_MODEM: src_code = `UICF_SRC_MODEM;
      uicf_pkg::UICF_SEL_XOFF: src_code = `UICF_SRC_XOFF;
      uicf_pkg::UICF_SEL_FLOW: src_code = `UICF_SRC_FLOW;
      default: src_code = `UICF_SRC_NONE; // see R9
    endcase
  end
  assign source_byte = {{2{fifo_en}}, src_code}; // see R11
  assign irq_o = ~src_code[0]; // see R26

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dat_o <= 32'h0000_0000;
    end else if (rd) begin
      case (adr_i)
        `UICF_OFS_MASK: dat_o <= {24'h00_0000, interrupt_mask};
        `UICF_OFS_SOURCE: dat_o <= {24'h00_0000, source_byte};
        `UICF_OFS_EXT_CTRL: dat_o <= {24'h00_0000, ext_ctrl};
        `UICF_OFS_LINE_STATUS: dat_o <= {24'h00_0000, line_status};
        `UICF_OFS_MODEM_STATUS:
          dat_o <= {24'h00_0000, modem_level_i, modem_status};
        `UICF_OFS_RX_LEVEL: dat_o <= 32'(rx_level_i);
        `UICF_OFS_TX_LEVEL: dat_o <= 32'(tx_level_i);
        `UICF_OFS_TIMEOUT: dat_o <= {16'h0000, tmo_cnt};
        default: dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

/* rtl/uicf_cfg.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef UICF_CFG_SVH
`define UICF_CFG_SVH

// Byte addresses on the register bus
`define UICF_OFS_MASK 8'h00
`define UICF_OFS_SOURCE 8'h04
`define UICF_OFS_SETUP 8'h08
`define UICF_OFS_EXT_CTRL 8'h0C
`define UICF_OFS_LINE_STATUS 8'h10
`define UICF_OFS_MODEM_STATUS 8'h14
`define UICF_OFS_RX_LEVEL 8'h18
`define UICF_OFS_TX_LEVEL 8'h1C
`define UICF_OFS_TIMEOUT 8'h20

// interrupt_mask fields
`define UICF_MASK_RXDATA 0
`define UICF_MASK_TXREADY 1
`define UICF_MASK_LINE 2
`define UICF_MASK_MODEM 3
`define UICF_MASK_XOFF 5
`define UICF_MASK_RTS 6
`define UICF_MASK_CTS 7

// fifo_setup fields
`define UICF_SETUP_EN 0
`define UICF_SETUP_RXRST 1
`define UICF_SETUP_TXRST 2
`define UICF_SETUP_DMA 3

// Extended control register fields
`define UICF_EXT_ENH 0
`define UICF_EXT_AUTO_CTS 1
`define UICF_EXT_AUTO_RTS 2
`define UICF_EXT_RS485 3
`define UICF_EXT_IMM_ERR 4
`define UICF_EXT_TBL_LO 5
`define UICF_EXT_TBL_HI 6

// Encoded source values
`define UICF_SRC_LINE 6'h06
`define UICF_SRC_TIMEOUT 6'h0C
`define UICF_SRC_RXDATA 6'h04
`define UICF_SRC_TXREADY 6'h02
`define UICF_SRC_MODEM 6'h00
`define UICF_SRC_XOFF 6'h10
`define UICF_SRC_FLOW 6'h20
`define UICF_SRC_NONE 6'h01

// Timeout: four characters plus twelve bits
`define UICF_TMO_CHARS 4
`define UICF_TMO_BITS 12
`define UICF_RESET_BYTE 8'h00
`define UICF_BIT_TIME_RESET 16'h0364

`endif

/* rtl/uicf_pkg.sv */
// Types shared by the interrupt and FIFO control block
package uicf_pkg;
  typedef enum logic [2:0] {
    UICF_SEL_NONE = 3'h0,
    UICF_SEL_LINE = 3'h1,
    UICF_SEL_TIMEOUT = 3'h3,
    UICF_SEL_RXDATA = 3'h2,
    UICF_SEL_TXREADY = 3'h6,
    UICF_SEL_MODEM = 3'h7,
    UICF_SEL_XOFF = 3'h5,
    UICF_SEL_FLOW = 3'h4
  } uicf_sel_t;
endpackage

/* verif/uicf_ctrl_props.sv */
// Checker for the interrupt and FIFO control block
`include "uicf_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module uicf_ctrl_props (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Register bus
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // Control outputs
  input wire logic fifo_en_o,
  input wire logic rx_fifo_clr_o,
  input wire logic tx_fifo_clr_o,
  input wire logic dma_mode_o,
  input wire logic sleep_en_o,
  input wire logic irq_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  wire logic rd_src = ack_o && !we_i && adr_i == `UICF_OFS_SOURCE;
  wire logic wr_set = ack_o && we_i && sel_i[0]
    && adr_i == `UICF_OFS_SETUP;

  property p_irq_src;
    rd_src |-> dat_o[0] == !$past(irq_o);
  endproperty
  a_irq_src: assert property (p_irq_src)
    else $error("source bit 0 disagrees with irq");
  property p_code;
    rd_src |-> dat_o[5:0] inside {6'h06, 6'h0C, 6'h04, 6'h02, 6'h00,
      6'h10, 6'h20, 6'h01};
  endproperty
  a_code: assert property (p_code)
    else $error("illegal source code");
  property p_fifo_bits;
    rd_src |-> dat_o[7:6] == {2{$past(fifo_en_o)}};
  endproperty
  a_fifo_bits: assert property (p_fifo_bits)
    else $error("source bits 7:6 wrong");
  property p_en;
    $changed(fifo_en_o) |-> wr_set && fifo_en_o == dat_i[0];
  endproperty
  a_en: assert property (p_en)
    else $error("fifo enable changed without setup write");
  property p_dma;
    $changed(dma_mode_o) |-> wr_set && dat_i[0] && dma_mode_o == dat_i[3];
  endproperty
  a_dma: assert property (p_dma)
    else $error("dma mode changed without enabled write");
  property p_rx_clr;
    rx_fifo_clr_o |-> fifo_en_o && (wr_set || $past(wr_set))
      ##1 !rx_fifo_clr_o;
  endproperty
  a_rx_clr: assert property (p_rx_clr)
    else $error("bad receive clear pulse");
  property p_tx_clr;
    tx_fifo_clr_o |-> fifo_en_o && (wr_set || $past(wr_set))
      ##1 !tx_fifo_clr_o;
  endproperty
  a_tx_clr: assert property (p_tx_clr)
    else $error("bad transmit clear pulse");
  property p_sleep;
    $changed(sleep_en_o) |-> ack_o && we_i
      && adr_i inside {`UICF_OFS_MASK, `UICF_OFS_EXT_CTRL};
  endproperty
  a_sleep: assert property (p_sleep)
    else $error("sleep enable changed without write");
  c_pend: cover property (rd_src && !dat_o[0]);
  c_rx_clr: cover property (rx_fifo_clr_o);
  c_tx_clr: cover property (tx_fifo_clr_o);
endmodule

bind uicf_ctrl uicf_ctrl_props props_u (.sys_clk_i(sys_clk_i),
  .rst_b_i(rst_b_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i),
  .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .fifo_en_o(fifo_en_o),
  .rx_fifo_clr_o(rx_fifo_clr_o), .tx_fifo_clr_o(tx_fifo_clr_o),
  .dma_mode_o(dma_mode_o), .sleep_en_o(sleep_en_o), .irq_o(irq_o));
`default_nettype wire

/* verif/uicf_host.sv */
// Host processor model: classic single-cycle bus master
`timescale 1ns/1ns
`default_nettype none
module uicf_host (
  // Clock
  input wire logic sys_clk_i,
  // Bus request
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [3:0] sel_o,
  output logic [31:0] dat_o,
  // Bus answer
  input wire logic [31:0] dat_i,
  input wire logic ack_i,
  input wire logic err_i
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'hFF;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
  end

  // Held until ack or err is sampled; address inverted once released
  task automatic cycle(input logic w, input logic [7:0] a,
      input logic [7:0] wd, output logic [31:0] rd, output logic e);
    @(posedge sys_clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= 4'h1;
    dat_o <= {24'h00_0000, wd};
    do @(posedge sys_clk_i); while (ack_i !== 1'b1 && err_i !== 1'b1);
    rd = dat_i;
    e = err_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    adr_o <= ~a;
    dat_o <= ~{24'h00_0000, wd};
  endtask
endmodule
`default_nettype wire

/* verif/uicf_ctrl_bench.sv */
// Self-checking bench for the interrupt and FIFO control block
`include "uicf_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module uicf_ctrl_bench;
  localparam logic [7:0] a_msk = `UICF_OFS_MASK;
  localparam logic [7:0] a_src = `UICF_OFS_SOURCE;
  localparam logic [7:0] a_set = `UICF_OFS_SETUP;
  localparam logic [7:0] a_ext = `UICF_OFS_EXT_CTRL;
  localparam logic [7:0] a_line = `UICF_OFS_LINE_STATUS;
  localparam logic [7:0] a_mdm = `UICF_OFS_MODEM_STATUS;
  logic sys_clk_i, rst_b_i, cyc_i, stb_i, we_i, ack_o, err_o, e;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, r;
  logic [9:0] ev;
  logic [2:0] rx_head_err_i;
  logic [6:0] rx_level_i, tx_level_i;
  logic tx_all_empty_i, rts_out_i, cts_pin_i, rx_xon_match_i;
  logic fifo_en_o, rx_fifo_clr_o, tx_fifo_clr_o, dma_mode_o;
  logic sleep_en_o, irq_o;
  wire logic [3:0] modem_delta_i;
  wire logic rx_char_push_i, rx_char_pop_i, rx_overrun_i, rx_xoff_match_i;
  wire logic rx_special_match_i, tx_push_i;
  wire logic bit_tick_i;
  int err_total, compares, cycles, n_rx_clr, n_tx_clr;

  // Event pulses: bit0 push, 1 pop, 2 overrun, 3 xoff, 4 special,
  // 5 transmit write, 9:6 modem deltas
  assign {modem_delta_i, tx_push_i, rx_special_match_i, rx_xoff_match_i,
    rx_overrun_i, rx_char_pop_i, rx_char_push_i} = ev;
  assign bit_tick_i = (cycles[3:0] == 4'h0);

  uicf_ctrl #(.FIFO_DEPTH(64), .LVL_W(7)) dut_u (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .err_o(err_o), .rx_char_push_i(rx_char_push_i),
    .rx_char_pop_i(rx_char_pop_i), .rx_overrun_i(rx_overrun_i),
    .rx_head_err_i(rx_head_err_i), .rx_xoff_match_i(rx_xoff_match_i),
    .rx_xon_match_i(rx_xon_match_i),
    .rx_special_match_i(rx_special_match_i),
    .modem_delta_i(modem_delta_i), .modem_level_i(4'h0),
    .rx_level_i(rx_level_i), .tx_level_i(tx_level_i),
    .tx_push_i(tx_push_i), .tx_all_empty_i(tx_all_empty_i),
    .rts_out_i(rts_out_i), .cts_pin_i(cts_pin_i), .char_bits_i(4'hA),
    .bit_tick_i(bit_tick_i), .fifo_en_o(fifo_en_o),
    .rx_fifo_clr_o(rx_fifo_clr_o), .tx_fifo_clr_o(tx_fifo_clr_o),
    .dma_mode_o(dma_mode_o), .sleep_en_o(sleep_en_o), .irq_o(irq_o));

  uicf_host host_u (.sys_clk_i(sys_clk_i), .cyc_o(cyc_i), .stb_o(stb_i),
    .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i),
    .dat_i(dat_o), .ack_i(ack_o), .err_i(err_o));

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    cycles <= cycles + 1;
    if (rx_fifo_clr_o === 1'b1) n_rx_clr <= n_rx_clr + 1;
    if (tx_fifo_clr_o === 1'b1) n_tx_clr <= n_tx_clr + 1;
    if (cycles == 8000) begin
      err_total = err_total + 1;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    compares = compares + 1;
    if (g !== x) begin
      err_total = err_total + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.cycle(1'b1, a, d, r, e);
  endtask

  task automatic rd(input logic [7:0] a);
    host_u.cycle(1'b0, a, 8'h00, r, e);
  endtask

  task automatic rc(input logic [7:0] a, input logic [7:0] x);
    rd(a);
    chk(r[7:0], x);
  endtask

  task automatic pulse(input logic [9:0] m);
    @(posedge sys_clk_i);
    ev <= m;
    @(posedge sys_clk_i);
    ev <= 10'h000;
    repeat (3) @(posedge sys_clk_i);
  endtask

  initial begin
    rst_b_i = 1'b0;
    ev = 10'h000;
    rx_head_err_i = 3'h0;
    rx_level_i = 7'h00;
    tx_level_i = 7'h00;
    tx_all_empty_i = 1'b1;
    rts_out_i = 1'b0;
    cts_pin_i = 1'b0;
    rx_xon_match_i = 1'b0;
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rc(a_src, 8'h01);
    rc(a_msk, 8'h00);
    rd(8'h40);
    chk({7'h00, e}, 8'h01);
    wr(a_msk, 8'h01);
    rx_level_i <= 7'h01;
    pulse(10'h001);
    chk({7'h00, irq_o}, 8'h01);
    rc(a_src, 8'h04);
    rx_level_i <= 7'h00;
    pulse(10'h002);
    rc(a_src, 8'h01);
    wr(a_msk, 8'h0C);
    rx_head_err_i <= 3'h1;
    repeat (3) @(posedge sys_clk_i);
    rc(a_src, 8'h01);
    pulse(10'h002);
    rx_head_err_i <= 3'h0;
    rc(a_src, 8'h06);
    rd(a_line);
    rc(a_src, 8'h01);
    wr(a_ext, 8'h10);
    rx_head_err_i <= 3'h2;
    repeat (3) @(posedge sys_clk_i);
    rc(a_src, 8'h06);
    rx_head_err_i <= 3'h0;
    rd(a_line);
    rc(a_src, 8'h01);
    wr(a_ext, 8'h00);
    pulse(10'h044);
    rc(a_src, 8'h06);
    rd(a_line);
    rc(a_src, 8'h00);
    rd(a_mdm);
    rc(a_src, 8'h01);
    for (int i = 0; i < 4; i++) begin
      pulse({4'h1 << i, 6'h00});
      rc(a_src, 8'h00);
      rd(a_mdm);
    end
    wr(a_msk, 8'h02);
    rc(a_src, 8'h02);
    rc(a_src, 8'h01);
    tx_all_empty_i <= 1'b0;
    tx_level_i <= 7'h01;
    repeat (2) @(posedge sys_clk_i);
    tx_all_empty_i <= 1'b1;
    tx_level_i <= 7'h00;
    repeat (3) @(posedge sys_clk_i);
    chk({7'h00, irq_o}, 8'h01);
    pulse(10'h020);
    chk({7'h00, irq_o}, 8'h00);
    wr(a_ext, 8'h08);
    tx_all_empty_i <= 1'b0;
    rc(a_src, 8'h01);
    tx_all_empty_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    rc(a_src, 8'h02);
    rc(a_src, 8'h01);
    wr(a_ext, 8'h00);
    wr(a_msk, 8'h10);
    chk({7'h00, sleep_en_o}, 8'h00);
    wr(a_ext, 8'h01);
    chk({7'h00, sleep_en_o}, 8'h01);
    wr(a_msk, 8'h20);
    for (int k = 0; k < 2; k++) begin
      pulse(k == 0 ? 10'h008 : 10'h010);
      rc(a_src, 8'h10);
      rc(a_src, 8'h01);
    end
    pulse(10'h008);
    pulse(10'h001);
    rc(a_src, 8'h10);
    pulse(10'h008);
    rx_xon_match_i <= 1'b1;
    @(posedge sys_clk_i);
    rx_xon_match_i <= 1'b0;
    rc(a_src, 8'h01);
    pulse(10'h010);
    pulse(10'h001);
    rc(a_src, 8'h01);
    wr(a_msk, 8'hC0);
    for (int i = 0; i < 2; i++) begin
      for (int m = 0; m < 2; m++) begin
        wr(a_ext, m == 0 ? 8'h01 : (i == 0 ? 8'h03 : 8'h05));
        if (i == 0) cts_pin_i <= 1'b1;
        else rts_out_i <= 1'b1;
        repeat (5) @(posedge sys_clk_i);
        rc(a_src, m == 0 ? 8'h01 : 8'h20);
        rd(a_mdm);
        rc(a_src, 8'h01);
        cts_pin_i <= 1'b0;
        rts_out_i <= 1'b0;
        repeat (5) @(posedge sys_clk_i);
      end
    end
    wr(a_ext, 8'h00);
    wr(a_msk, 8'h00);
    wr(a_set, 8'h01);
    rc(a_src, 8'hC1);
    wr(a_set, 8'h41);
    wr(a_msk, 8'h01);
    rx_level_i <= 7'h01;
    pulse(10'h001);
    repeat (715) @(posedge sys_clk_i);
    rc(a_src, 8'hC1);
    repeat (130) @(posedge sys_clk_i);
    rc(a_src, 8'hCC);
    rx_level_i <= 7'h00;
    pulse(10'h002);
    rc(a_src, 8'hC1);
    wr(a_set, 8'h07);
    wr(a_set, 8'h09);
    chk({6'h00, fifo_en_o, dma_mode_o}, 8'h03);
    wr(a_set, 8'h0E);
    repeat (2) @(posedge sys_clk_i);
    chk({6'h00, fifo_en_o, dma_mode_o}, 8'h01);
    chk(n_rx_clr[7:0], 8'h01);
    chk(n_tx_clr[7:0], 8'h01);
    rc(a_src, 8'h01);
    tally_and_finish();
  end
endmodule
`default_nettype wire
